// [eep_defines.vh]
// Shared constants for the serial EEPROM slave logic
`ifndef EEP_DEFINES_VH
`define EEP_DEFINES_VH

// Fixed device-type code in the top nibble of the slave address byte
`define EEP_DEV_TYPE     4'hA
// Number of chip-select strap / high-address bits in the slave address
`define EEP_SEL_BITS     3
// Address width of the largest array (2048 bytes)
`define EEP_ADDR_W       11
// Page write buffer: 16 bytes, 4 in-page address bits
`define EEP_PAGE_BYTES   16
`define EEP_PAGE_W       4
// Bits in one byte on the wire, and the acknowledge clock index
`define EEP_BYTE_BITS    4'h8
// Longest self-timed programming time, in milliseconds
`define EEP_TWR_MS       10
// System clock rate in kHz (200 MHz)
`define EEP_CLK_KHZ      200000
// Programming time in system clock cycles (longest time: exact product)
`define EEP_TWR_CYC      (`EEP_TWR_MS * `EEP_CLK_KHZ)
// Synchroniser depth for pins
`define EEP_SYNC_STAGES  2
// Transaction phases (which byte the slave is receiving)
`define EEP_PH_DEV       2'h0
`define EEP_PH_WADDR     2'h1
`define EEP_PH_DATA      2'h2

`endif

// [eep_sync.v]
// Two-flop synchroniser for pins sampled by the system clock
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"

module eep_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_clk_sys,
   input  wire             i_reset,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // First stage feeds only the second stage
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         meta_r <= {WIDTH{1'b1}};
         sync_r <= {WIDTH{1'b1}};
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule // eep_sync
`default_nettype wire

// [eep_mem.v]
// Memory array in flip-flops with the 16-byte page write buffer
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"

module eep_mem #(
   parameter ADDR_W = `EEP_ADDR_W
) (
   input  wire                         i_clk_sys,
   input  wire                         i_reset,
   input  wire                         i_buf_clr,
   input  wire                         i_buf_we,
   input  wire [`EEP_PAGE_W-1:0]       i_buf_idx,
   input  wire [7:0]                   i_buf_data,
   input  wire                         i_commit,
   input  wire [ADDR_W-`EEP_PAGE_W-1:0] i_page,
   input  wire [ADDR_W-1:0]            i_rd_addr,
   output wire [7:0]                   o_rd_data
);

   localparam DEPTH = 1 << ADDR_W;

   reg [7:0]                  mem_r [0:DEPTH-1];
   reg [7:0]                  buf_r [0:`EEP_PAGE_BYTES-1];
   reg [`EEP_PAGE_BYTES-1:0]  vld_r;
   integer                    i;

   // Buffer valid bits: cleared per transaction and after programming
   always @(posedge i_clk_sys) begin
      if (i_reset || i_buf_clr || i_commit) begin
         vld_r <= {`EEP_PAGE_BYTES{1'b0}};
      end else if (i_buf_we) begin
         vld_r[i_buf_idx] <= 1'b1;
      end
   end

   // Buffer data; a wrapped index overwrites the earlier byte
   always @(posedge i_clk_sys) begin
      if (i_buf_we) begin
         buf_r[i_buf_idx] <= i_buf_data;
      end
   end

   // All buffered bytes of the page land in the array at once
   always @(posedge i_clk_sys) begin
      if (i_commit) begin
         for (i = 0; i < `EEP_PAGE_BYTES; i = i + 1) begin
            if (vld_r[i]) begin
               mem_r[{i_page, i[`EEP_PAGE_W-1:0]}] <= buf_r[i];
            end
         end
      end
   end

   assign o_rd_data = mem_r[i_rd_addr];

endmodule // eep_mem
`default_nettype wire

// [eep_slave.v]
// Serial EEPROM two-wire slave: command, page write and read logic
//
// How it works
// - Byte write: address, word address, data, all acked
// - STOP after write data starts programming
// - Programming: ignore everything, acknowledge nothing
// - Page write stores up to 16 bytes
// - Writes step only in-page address bits
// - Over 16 bytes wraps, overwriting buffered bytes
// - STOP programs whole buffered page at once
// - Polled address unacked while still programming
// - Polled address acked once programming ends
// - Write-protect pin locks upper array half
// - Protected write: nack first data, program nothing
// - Read direction bit one puts slave transmitting
// - One counter: last address plus one, wraps
// - Immediate read sends byte at counter
// - Repeated START read returns selected byte
// - Master ack fetches next byte
// - Master nack ends read, line released
// - Reads increment all address bits
// - Slave address 1010 plus straps or address
// - Slave address supplies upper memory address bits
// - Receiver acks by pulling data low clock nine
// - Programming ends within 10 ms, bus disabled
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"

module eep_slave #(
   parameter        ADDR_W  = `EEP_ADDR_W,
   parameter [31:0] TWR_CYC = `EEP_TWR_CYC
) (
   input  wire                     i_clk_sys,
   input  wire                     i_reset,
   input  wire                     i_scl,
   input  wire                     i_sda,
   output wire                     o_sda_out,
   output wire                     o_sda_oe,
   input  wire                     i_wp,
   input  wire [`EEP_SEL_BITS-1:0] i_chip_select_straps,
   output wire                     o_busy
);

   // One-hot states of the byte engine
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_RX   = 6'h02;
   localparam [5:0] ST_ACK  = 6'h04;
   localparam [5:0] ST_TX   = 6'h08;
   localparam [5:0] ST_RACK = 6'h10;
   localparam [5:0] ST_WAIT = 6'h20;

   localparam HI_W = ADDR_W - `EEP_PAGE_W;

   wire [`EEP_SEL_BITS+2:0] pins_s;
   wire                     scl_s;
   wire                     sda_s;
   wire                     wp_s;
   wire [`EEP_SEL_BITS-1:0] straps_s;

   reg  [5:0]               state_r;
   reg  [1:0]               phase_r;
   reg  [3:0]               cnt_r;
   reg  [7:0]               sh_r;
   reg  [7:0]               tx_r;
   reg                      rw_r;
   reg                      rack_r;
   reg  [`EEP_SEL_BITS-1:0] devhi_r;
   reg  [ADDR_W-1:0]        addr_r;
   reg                      have_data_r;
   reg                      busy_r;
   reg  [31:0]              tmr_r;
   reg                      sda_oe_r;
   reg                      sda_out_r;
   reg                      scl_q_r;
   reg                      sda_q_r;
   reg                      buf_clr_r;
   reg                      buf_we_r;
   reg  [`EEP_PAGE_W-1:0]   buf_idx_r;
   reg  [7:0]               buf_data_r;
   reg                      commit_r;

   wire                     scl_rise;
   wire                     scl_fall;
   wire                     bus_start;
   wire                     bus_stop;
   wire [`EEP_SEL_BITS-1:0] sel_ok;
   wire                     dev_match;
   wire [ADDR_W-1:0]        word_addr;
   wire                     wr_protected;
   wire [7:0]               rd_data;

   // Pins cross into the system clock through two flops
   eep_sync #(
      .WIDTH (`EEP_SEL_BITS + 3)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_async   ({i_chip_select_straps, i_wp, i_sda, i_scl}),
      .o_sync    (pins_s)
   );

   assign scl_s    = pins_s[0];
   assign sda_s    = pins_s[1];
   assign wp_s     = pins_s[2];
   assign straps_s = pins_s[`EEP_SEL_BITS+2:3];

   // Previous synchronised levels for edge and condition detection
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   // Clock edges, and data changes while the clock is high
   assign scl_rise  = scl_s & ~scl_q_r;
   assign scl_fall  = ~scl_s & scl_q_r;
   assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

   // Per select bit: memory address bit for big arrays, else strap match
   genvar g;
   generate
      for (g = 0; g < `EEP_SEL_BITS; g = g + 1) begin : g_sel
         if (g < ADDR_W - 8) begin : g_mem
            assign sel_ok[g] = 1'b1;
         end else begin : g_pin
            assign sel_ok[g] = (sh_r[g+1] == straps_s[g]);
         end
      end
   endgenerate

   // Type code 1010 and select bits must all agree
   assign dev_match = (sh_r[7:4] == `EEP_DEV_TYPE) && (&sel_ok);

   // Full word address: byte address plus slave-address high bits
   assign word_addr[7:0] = sh_r;
   generate
      for (g = 8; g < ADDR_W; g = g + 1) begin : g_hi
         assign word_addr[g] = devhi_r[g-8];
      end
   endgenerate

   // Upper half is read-only while the protect pin is high
   assign wr_protected = wp_s & addr_r[ADDR_W-1];

   // Array and page buffer
   eep_mem #(
      .ADDR_W (ADDR_W)
   ) u_mem (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_buf_clr  (buf_clr_r),
      .i_buf_we   (buf_we_r),
      .i_buf_idx  (buf_idx_r),
      .i_buf_data (buf_data_r),
      .i_commit   (commit_r),
      .i_page     (addr_r[ADDR_W-1:`EEP_PAGE_W]),
      .i_rd_addr  (addr_r),
      .o_rd_data  (rd_data)
   );

   // Self-timed programming: busy until the timer runs out
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         busy_r   <= 1'b0;
         tmr_r    <= 32'h0000_0000;
         commit_r <= 1'b0;
      end else begin
         commit_r <= 1'b0;
         if (!busy_r) begin
            if (bus_stop && have_data_r) begin
               busy_r <= 1'b1;
               tmr_r  <= TWR_CYC - 32'h0000_0001;
            end
         end else if (tmr_r == 32'h0000_0000) begin
            busy_r   <= 1'b0;
            commit_r <= 1'b1;
         end else begin
            tmr_r <= tmr_r - 32'h0000_0001;
         end
      end
   end

   // Byte engine: receive, acknowledge, transmit
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_r     <= ST_IDLE;
         phase_r     <= `EEP_PH_DEV;
         cnt_r       <= 4'h0;
         sh_r        <= 8'h00;
         tx_r        <= 8'h00;
         rw_r        <= 1'b0;
         rack_r      <= 1'b0;
         devhi_r     <= {`EEP_SEL_BITS{1'b0}};
         addr_r      <= {ADDR_W{1'b0}};
         have_data_r <= 1'b0;
         sda_oe_r    <= 1'b0;
         sda_out_r   <= 1'b0;
         buf_clr_r   <= 1'b0;
         buf_we_r    <= 1'b0;
         buf_idx_r   <= {`EEP_PAGE_W{1'b0}};
         buf_data_r  <= 8'h00;
      end else begin
         buf_clr_r <= 1'b0;
         buf_we_r  <= 1'b0;
         if (busy_r) begin
            // Bus interface disabled: line released, nothing heard
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
         end else if (bus_start) begin
            // START or repeated START: pending write data is dropped
            state_r     <= ST_RX;
            phase_r     <= `EEP_PH_DEV;
            cnt_r       <= 4'h0;
            sda_oe_r    <= 1'b0;
            have_data_r <= 1'b0;
            buf_clr_r   <= 1'b1;
         end else if (bus_stop) begin
            // Timer block starts programming if data was taken
            state_r     <= ST_IDLE;
            sda_oe_r    <= 1'b0;
            have_data_r <= 1'b0;
         end else begin
            case (state_r)
               ST_RX: begin
                  if (scl_rise && cnt_r != `EEP_BYTE_BITS) begin
                     sh_r  <= {sh_r[6:0], sda_s};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == `EEP_BYTE_BITS) begin
                     // Byte complete: decide the acknowledge
                     state_r  <= ST_ACK;
                     sda_oe_r <= 1'b1;
                     case (phase_r)
                        `EEP_PH_DEV: begin
                           if (!dev_match) begin
                              state_r  <= ST_WAIT;
                              sda_oe_r <= 1'b0;
                           end else begin
                              rw_r    <= sh_r[0];
                              devhi_r <= sh_r[3:1];
                              phase_r <= `EEP_PH_WADDR;
                           end
                        end
                        `EEP_PH_WADDR: begin
                           // Load the counter; page bits now fixed
                           addr_r    <= word_addr;
                           phase_r   <= `EEP_PH_DATA;
                           buf_clr_r <= 1'b1;
                        end
                        `EEP_PH_DATA: begin
                           if (wr_protected) begin
                              // Refuse data, abandon the page
                              state_r     <= ST_WAIT;
                              sda_oe_r    <= 1'b0;
                              have_data_r <= 1'b0;
                              buf_clr_r   <= 1'b1;
                           end else begin
                              buf_we_r    <= 1'b1;
                              buf_idx_r   <= addr_r[`EEP_PAGE_W-1:0];
                              buf_data_r  <= sh_r;
                              have_data_r <= 1'b1;
                              // Only the in-page bits step, and wrap
                              addr_r[`EEP_PAGE_W-1:0] <=
                                 addr_r[`EEP_PAGE_W-1:0] +
                                 {{(`EEP_PAGE_W-1){1'b0}}, 1'b1};
                           end
                        end
                        default: begin
                           state_r  <= ST_WAIT;
                           sda_oe_r <= 1'b0;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  // Hold the acknowledge through the ninth clock
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (phase_r == `EEP_PH_WADDR && rw_r) begin
                        // Read: first bit goes out at this fall
                        state_r  <= ST_TX;
                        tx_r     <= rd_data;
                        sda_oe_r <= ~rd_data[7];
                     end else begin
                        state_r  <= ST_RX;
                        sda_oe_r <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_r == `EEP_BYTE_BITS) begin
                        // Byte sent: release for the master's answer
                        state_r  <= ST_RACK;
                        sda_oe_r <= 1'b0;
                        rack_r   <= 1'b0;
                        addr_r   <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
                     end else begin
                        tx_r     <= {tx_r[6:0], 1'b0};
                        sda_oe_r <= ~tx_r[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     rack_r <= ~sda_s;
                  end else if (scl_fall) begin
                     if (rack_r) begin
                        // Master wants more: next byte of the array
                        state_r  <= ST_TX;
                        cnt_r    <= 4'h0;
                        tx_r     <= rd_data;
                        sda_oe_r <= ~rd_data[7];
                     end else begin
                        state_r <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  // Line released until the next START or STOP
                  sda_oe_r <= 1'b0;
               end
               default: begin
                  // Idle holds until a START
                  state_r  <= ST_IDLE;
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain pin: the driven level is always low
   assign o_sda_out = sda_out_r;
   assign o_sda_oe  = sda_oe_r;
   assign o_busy    = busy_r;

endmodule // eep_slave
`default_nettype wire

// [eep_slave_chk.sv]
// Checker on the slave ports: acknowledge timing and programming cycle
`timescale 1ns/1ps
`default_nettype none
module eep_slave_chk #(
   parameter        ADDR_W  = 11,
   parameter [31:0] TWR_CYC = 32'h001E_8480
) (
   input wire       i_clk_sys,
   input wire       i_reset,
   input wire       i_scl,
   input wire       i_sda,
   input wire       o_sda_out,
   input wire       o_sda_oe,
   input wire       i_wp,
   input wire [2:0] i_chip_select_straps,
   input wire       o_busy
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   logic [31:0] busy_cnt_r;
   logic [31:0] busy_cnt_nxt;

   // Length of the running programming cycle
   always_comb busy_cnt_nxt = o_busy ? busy_cnt_r + 32'h1 : 32'h0;
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         busy_cnt_r <= 32'h0;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end

   // Steps of an acknowledge or data bit and of a stop
   sequence ack_begin;
      $rose(o_sda_oe);
   endsequence
   sequence ack_held;
      o_sda_oe [*8];
   endsequence
   sequence stop_seen;
      i_scl && $rose(i_sda);
   endsequence

   reset_quiet_a: assert property ($fell(i_reset) |-> !o_busy && !o_sda_oe)
      else $error("outputs active right after reset");
   busy_mute_a: assert property (o_busy |-> !o_sda_oe)
      else $error("data line driven while programming");
   busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_r == TWR_CYC)
      else $error("programming time wrong");
   busy_cause_a: assert property ($rose(o_busy) |-> i_scl && i_sda)
      else $error("programming began without a stop");
   ack_hold_a: assert property (ack_begin |-> ack_held)
      else $error("acknowledge pulse too short");
   drive_low_a: assert property (o_sda_oe |-> !o_sda_out)
      else $error("driven data not low");
   oe_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data drive changed while clock high");
   stop_release_a: assert property (stop_seen |=> !o_sda_oe [*4])
      else $error("data line held after stop");
endmodule // eep_slave_chk

bind eep_slave eep_slave_chk #(
   .ADDR_W (ADDR_W),
   .TWR_CYC(TWR_CYC)
) u_chk (
   .i_clk_sys           (i_clk_sys),
   .i_reset             (i_reset),
   .i_scl               (i_scl),
   .i_sda               (i_sda),
   .o_sda_out           (o_sda_out),
   .o_sda_oe            (o_sda_oe),
   .i_wp                (i_wp),
   .i_chip_select_straps(i_chip_select_straps),
   .o_busy              (o_busy)
);
`default_nettype wire

// [eep_i2c_master.sv]
// Bus master model driving the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module eep_i2c_master (
   output var logic o_scl,
   output var logic o_sda,
   input  wire      i_sda
);
   localparam int Q = 16; // Quarter of a 64 ns bus clock

   // Both lines released at start-up
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // Start or repeated start: data falls while clock high
   task automatic start();
      #Q o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b0;
   endtask

   // Stop: data rises while clock high, then lines stay released
   task automatic stop();
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda = 1'b1;
      #Q;
   endtask

   // One clock; data set while low, wire level taken while high
   task automatic bit_clk(input logic b, output logic s);
      #Q o_sda = b;
      #Q o_scl = 1'b1;
      #Q s = i_sda;
      #Q o_scl = 1'b0;
   endtask

   // Byte out, most significant bit first, then the ninth clock
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_clk(d[i], s);
      bit_clk(1'b1, s);
      ack = ~s;
   endtask

   // Byte in; the ninth clock asks for more or ends the read
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_clk(1'b1, s);
         d[i] = s;
      end
      bit_clk(~more, s);
      o_sda = 1'b1;
   endtask
endmodule // eep_i2c_master
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk;
   logic       rst;
   logic       wp;
   logic [2:0] straps;
   logic       scl;
   logic       sda_m;
   logic       oe;
   logic       out;
   logic       busy;
   wire        sda = sda_m & ~oe; // Pull-up with two open drains
   int         bad_count;
   int         comparisons;
   int         cnt;
   int         mem [256];

   eep_slave #(.ADDR_W(8), .TWR_CYC(200)) dut (
      .i_clk_sys           (clk),
      .i_reset             (rst),
      .i_scl               (scl),
      .i_sda               (sda),
      .o_sda_out           (out),
      .o_sda_oe            (oe),
      .i_wp                (wp),
      .i_chip_select_straps(straps),
      .o_busy              (busy)
   );
   eep_i2c_master m (
      .o_scl(scl),
      .o_sda(sda_m),
      .i_sda(sda)
   );

   // Comparisons of data bytes and of single flags
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_bit(input logic e, input logic g);
      chk_byte({7'h0, e}, {7'h0, g});
   endtask

   function automatic logic [7:0] dev(input logic rd);
      return {4'hA, straps, rd};
   endfunction

   // Page write of n random bytes; a protected one stops at the first
   task automatic wr(input int a, input int n, input logic prot);
      logic       ack;
      logic [7:0] d;
      m.start();
      m.put_byte(dev(1'b0), ack);
      chk_bit(1'b1, ack);
      m.put_byte(a[7:0], ack);
      chk_bit(1'b1, ack);
      for (int i = 0; i < n && !(prot && i > 0); i++) begin
         d = 8'($urandom);
         m.put_byte(d, ack);
         chk_bit(!prot, ack);
         if (!prot) mem[(a & 'hF0) | ((a + i) & 'hF)] = d;
      end
      if (!prot) cnt = (a & 'hF0) | ((a + n) & 'hF);
      m.stop();
      repeat (6) @(negedge clk);
      chk_bit(!prot, busy);
   endtask

   // Polls with the write address until the slave answers again
   task automatic poll();
      logic ack;
      m.start();
      m.put_byte(dev(1'b0), ack);
      chk_bit(1'b0, ack);
      for (int i = 0; i < 20 && !ack; i++) begin
         m.start();
         m.put_byte(dev(1'b0), ack);
      end
      chk_bit(1'b1, ack);
   endtask

   // Read n bytes: 0 immediate, 1 selective, 2 selective after a poll
   task automatic rd_seq(input int a, input int n, input int sel);
      logic       ack;
      logic [7:0] d;
      if (sel != 2) m.start();
      if (sel == 1) begin
         m.put_byte(dev(1'b0), ack);
         chk_bit(1'b1, ack);
      end
      if (sel != 0) begin
         m.put_byte(a[7:0], ack);
         chk_bit(1'b1, ack);
         m.start();
         cnt = a;
      end
      m.put_byte(dev(1'b1), ack);
      chk_bit(1'b1, ack);
      for (int i = 0; i < n; i++) begin
         m.get_byte(i < n - 1, d);
         chk_byte(mem[cnt][7:0], d);
         cnt = (cnt + 1) % 256;
      end
      m.stop();
      repeat (6) @(negedge clk);
      chk_bit(1'b0, busy);
   endtask

   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // System clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Watchdog well beyond the expected run
   initial begin
      #300000;
      bad_count++;
      stop_test();
   end

   // Main sequence
   initial begin
      logic ack;
      rst = 1'b1;
      wp = 1'b0;
      straps = 3'h0;
      bad_count = 0;
      comparisons = 0;
      cnt = 0;
      void'($urandom(32'h3EEB6AB4));
      straps = 3'($urandom);
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      wr('h0E, 18, 1'b0);
      poll();
      rd_seq('h00, 15, 2);
      rd_seq(0, 1, 0);
      wr('hFF, 1, 1'b0);
      poll();
      rd_seq('hFF, 2, 2);
      // Full page: first byte plus the fifteen further bytes allowed
      wr('h30, 16, 1'b0);
      poll();
      rd_seq('h30, 16, 2);
      @(negedge clk) wp = 1'b1;
      wr('h80, 1, 1'b1);
      wr('hFF, 1, 1'b1);
      wr('h7F, 1, 1'b0);
      poll();
      rd_seq('h7F, 1, 2);
      rd_seq('hFF, 1, 1);
      for (int i = 0; i < 4; i++) begin
         m.start();
         m.put_byte(dev(1'b0) ^ (8'h02 << (2 * i)), ack);
         chk_bit(1'b0, ack);
         m.stop();
      end
      stop_test();
   end
endmodule // testbench
`default_nettype wire
